// File: include/tpw_defines.vh
// Constants of the three-phase inverter PWM control block.
// Assumes a single 25 MHz clock and an AXI4-Lite master with 32-bit data.
// What this block does
// - Mode 0: rate counter counts every underflow.
// - Skip mode: first irq n-1, then every n.
// - Dead time, phases, counter need unit enable.
// - Unit on, output off: all pins high-impedance.
// - Output enable clears on reset, trip, write, NMI.
// - Trip flag read-only, cleared by protect disable.
// - Mode-1 control has no effect in any mode.
// - Mode decode from sawtooth and mode-1 selects.
// - Secondary reloads alternate only in mode 1.
// - Buffers transfer once, or always in sawtooth.
// - Dead time starts on pulse fall or sawtooth transfer.
// - Transfer trigger is armed underflow or carrier write.
// - Shoot-through with protection floats all pins.
// - Interrupt rate one to fifteen carrier cycles.
`ifndef TPW_DEFINES_VH
`define TPW_DEFINES_VH
// ====================================================================
// Register offsets
`define TPW_OFF_PROTECT  8'h00
`define TPW_OFF_CTRL_A   8'h04
`define TPW_OFF_CTRL_B   8'h08
`define TPW_OFF_RATE     8'h0C
`define TPW_OFF_CARRIER  8'h10
`define TPW_OFF_TIMER    8'h14
`define TPW_OFF_BUFFER   8'h18
`define TPW_OFF_DUTY_U   8'h1C
`define TPW_OFF_DUTY_V   8'h20
`define TPW_OFF_DUTY_W   8'h24
`define TPW_OFF_DEADTIME 8'h28
`define TPW_OFF_STATUS   8'h2C
// ====================================================================
// Field positions
`define TPW_PR_RELEASE   1
`define TPW_A_SKIP       0
`define TPW_A_SYNC       1
`define TPW_A_UNIT       2
`define TPW_A_OE         3
`define TPW_A_STP        4
`define TPW_A_STFLAG     5
`define TPW_A_SAW        6
`define TPW_A_XFER       7
`define TPW_A_RW_MASK    8'h57
`define TPW_B_CWSEL      0
`define TPW_B_M1         1
`define TPW_B_M1CTL      3
`define TPW_B_DTDIS      5
`define TPW_B_DTTRIG     6
`define TPW_T_CSTART     0
`define TPW_T_PSTART     1
`define TPW_T_NMIEN      4
`define TPW_T_CRTS       5
// ====================================================================
// Reset values, modes and bus answers
`define TPW_RST_BYTE     8'h00
`define TPW_RST_WORD     16'h0000
`define TPW_RST_DT       8'h01
`define TPW_MODE_TRI0    2'h0
`define TPW_MODE_TRI1    2'h1
`define TPW_MODE_SAW     2'h2
`define TPW_RESP_OKAY    2'h0
`define TPW_RESP_SLVERR  2'h2
`endif

// File: hw/tpw_rate_ctr.v
// Carrier interrupt-rate counter.
// Assumes underflow and start inputs are one-cycle pulses.
`timescale 1ns/1ns
module tpw_rate_ctr #(
  parameter W = 4
) (
  clk,
  nrst,
  en,
  uf,
  mode1,
  skip,
  sync,
  start,
  wr,
  wval,
  nset,
  ucnt,
  irq
);
  input              clk;
  input              nrst;
  input              en;
  input              uf;
  input              mode1;
  input              skip;
  input              sync;
  input              start;
  input              wr;
  input  [W-1:0]     wval;
  output [W-1:0]     nset;
  output [W-1:0]     ucnt;
  output             irq;

  reg    [W-1:0]     nset_reg;
  reg    [W-1:0]     remain_reg;
  reg    [W-1:0]     ucnt_reg;
  reg                irq_reg;
  wire   [W-1:0]     n_src;
  wire   [W-1:0]     n_eff;
  wire               load_now;

  assign nset = nset_reg;
  assign ucnt = ucnt_reg;
  assign irq  = irq_reg;
  assign n_src = wr ? wval : nset_reg;
  assign n_eff = (n_src == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : n_src;
  assign load_now = sync ? start : wr;

  always @(posedge clk) begin
    if (!nrst) begin
      nset_reg   <= {W{1'b0}};
      remain_reg <= {W{1'b0}};
      ucnt_reg   <= {W{1'b0}};
      irq_reg    <= 1'b0;
    end else begin
      if (wr) begin
        nset_reg <= wval;
      end
      irq_reg <= 1'b0;
      if (!en) begin
        remain_reg <= {W{1'b0}};
        ucnt_reg   <= {W{1'b0}};
      end else if (load_now) begin
        remain_reg <= n_eff - {{(W-1){1'b0}}, 1'b1};
      end else if (uf) begin
        ucnt_reg <= ucnt_reg + {{(W-1){1'b0}}, 1'b1};
        if (!mode1 || !skip) begin
          irq_reg <= 1'b1;
        end else if (remain_reg <= {{(W-1){1'b0}}, 1'b1}) begin
          irq_reg    <= 1'b1;
          remain_reg <= n_eff;
        end else begin
          remain_reg <= remain_reg - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // tpw_rate_ctr

// File: hw/tpw_phase_ch.v
// One phase: one-shot timer, buffer pair sequencing and dead time.
// Assumes trig and xfer are one-cycle pulses on the system clock.
`timescale 1ns/1ns
module tpw_phase_ch #(
  parameter TW = 16,
  parameter DW = 8
) (
  clk,
  nrst,
  en,
  trig,
  alt_mode,
  alt_first,
  prim,
  sec,
  pair0,
  pair1,
  xfer,
  saw,
  dt_val,
  dt_dis,
  dt_trig_sel,
  out_pair
);
  input              clk;
  input              nrst;
  input              en;
  input              trig;
  input              alt_mode;
  input              alt_first;
  input  [TW-1:0]    prim;
  input  [TW-1:0]    sec;
  input  [1:0]       pair0;
  input  [1:0]       pair1;
  input              xfer;
  input              saw;
  input  [DW-1:0]    dt_val;
  input              dt_dis;
  input              dt_trig_sel;
  output [1:0]       out_pair;

  reg    [TW-1:0]    os_cnt_reg;
  reg                os_on_reg;
  reg                alt_sel_reg;
  reg                pair_sel_reg;
  reg    [1:0]       tgt_reg;
  reg    [1:0]       out_reg;
  reg    [DW-1:0]    dt_cnt_reg;
  reg                dt_run_reg;
  wire   [TW-1:0]    os_load;
  wire               os_fall;
  wire               apply;
  wire   [1:0]       pair;
  wire               dt_go;

  assign out_pair = out_reg;
  assign os_load = (alt_mode && alt_sel_reg) ? sec : prim;
  assign os_fall = os_on_reg && (os_cnt_reg == {{(TW-1){1'b0}}, 1'b1});
  // pulse fall, or transfer in sawtooth
  assign apply = os_fall || (saw && xfer);
  assign pair  = (pair_sel_reg && !xfer) ? pair1 : pair0;
  assign dt_go = dt_trig_sel ? (pair != out_reg) : 1'b1;

  always @(posedge clk) begin
    if (!nrst || !en) begin
      os_cnt_reg   <= {TW{1'b0}};
      os_on_reg    <= 1'b0;
      alt_sel_reg  <= 1'b0;
      pair_sel_reg <= 1'b0;
      tgt_reg      <= 2'h0;
      out_reg      <= 2'h0;
      dt_cnt_reg   <= {DW{1'b0}};
      dt_run_reg   <= 1'b0;
    end else begin
      if (trig) begin
        os_cnt_reg  <= os_load;
        os_on_reg   <= (os_load != {TW{1'b0}});
        alt_sel_reg <= alt_mode ? ~alt_sel_reg : 1'b0;
      end else if (os_on_reg) begin
        os_cnt_reg <= os_cnt_reg - {{(TW-1){1'b0}}, 1'b1};
        if (os_fall) begin
          os_on_reg <= 1'b0;
        end
      end
      if (!alt_mode) begin
        alt_sel_reg <= alt_first;
      end
      if (xfer && !apply) begin
        pair_sel_reg <= 1'b0;
      end
      if (apply) begin
        pair_sel_reg <= ~(pair_sel_reg && !xfer);
        tgt_reg      <= pair;
        if (dt_dis || !dt_go) begin
          out_reg <= pair;
        end else begin
          out_reg    <= out_reg & pair;
          dt_cnt_reg <= dt_val;
          dt_run_reg <= 1'b1;
        end
      end else if (dt_run_reg) begin
        if (dt_cnt_reg <= {{(DW-1){1'b0}}, 1'b1}) begin
          out_reg    <= tgt_reg;
          dt_run_reg <= 1'b0;
        end else begin
          dt_cnt_reg <= dt_cnt_reg - {{(DW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // tpw_phase_ch

// File: hw/tpw_top.v
// Three-phase inverter PWM control with an AXI4-Lite register slave.
// Assumes a synchronous NMI_N input and gate drivers on PHASE_OUT.
`timescale 1ns/1ns
`include "tpw_defines.vh"
module tpw_top #(
  parameter TW = 16,
  parameter DW = 8,
  parameter RW = 4
) (
  CORE_CLK,
  NRST,
  AWVALID,
  AWREADY,
  AWADDR,
  WVALID,
  WREADY,
  WDATA,
  WSTRB,
  BVALID,
  BREADY,
  BRESP,
  ARVALID,
  ARREADY,
  ARADDR,
  RVALID,
  RREADY,
  RDATA,
  RRESP,
  NMI_N,
  PHASE_OUT,
  PHASE_OE_N,
  CARRIER_IRQ
);
  input              CORE_CLK;
  input              NRST;
  input              AWVALID;
  output             AWREADY;
  input  [7:0]       AWADDR;
  input              WVALID;
  output             WREADY;
  input  [31:0]      WDATA;
  input  [3:0]       WSTRB;
  output             BVALID;
  input              BREADY;
  output [1:0]       BRESP;
  input              ARVALID;
  output             ARREADY;
  input  [7:0]       ARADDR;
  output             RVALID;
  input              RREADY;
  output [31:0]      RDATA;
  output [1:0]       RRESP;
  input              NMI_N;
  output [5:0]       PHASE_OUT;
  output [5:0]       PHASE_OE_N;
  output             CARRIER_IRQ;

  // ==================================================================
  // State
  reg                awready_reg;
  reg                wready_reg;
  reg                bvalid_reg;
  reg    [1:0]       bresp_reg;
  reg                arready_reg;
  reg                rvalid_reg;
  reg    [31:0]      rdata_reg;
  reg    [1:0]       rresp_reg;
  reg                aw_got_reg;
  reg                w_got_reg;
  reg    [7:0]       wa_reg;
  reg    [31:0]      wd_reg;
  reg    [3:0]       ws_reg;
  reg    [7:0]       prot_reg;
  reg    [7:0]       ctrl_a_reg;
  reg    [7:0]       ctrl_b_reg;
  reg    [7:0]       timer_reg;
  reg    [TW-1:0]    car_reg;
  reg    [TW-1:0]    car_lat_reg;
  reg    [TW-1:0]    car_cnt_reg;
  reg                car_run_reg;
  reg                alt_even_reg;
  reg    [15:0]      buf_reg;
  reg    [31:0]      duty_reg [0:2];
  reg    [DW-1:0]    dt_reg;
  reg                oe_reg;
  reg                st_flag_reg;
  reg                xfer_arm_reg;
  reg                buf_pend_reg;
  reg    [11:0]      shift_reg;
  reg    [1:0]       mode_reg;
  reg                nmi_prev_reg;
  reg    [5:0]       pin_out_reg;
  reg    [5:0]       pin_oe_n_reg;
  wire               wr_fire;
  wire   [31:0]      mw;
  wire               unit_en;
  wire               prot_ok;
  wire               uf;
  wire               car_start;
  wire               reload_ok;
  wire               wr_car;
  wire               xfer_trig;
  wire               xfer_pulse;
  wire   [5:0]       raw;
  wire               trip;
  wire               nmi_fall;
  wire               mode1_act;
  wire   [RW-1:0]    rate_n;
  wire   [RW-1:0]    rate_u;
  wire               rate_irq;
  integer            i;

  assign AWREADY     = awready_reg;
  assign WREADY      = wready_reg;
  assign BVALID      = bvalid_reg;
  assign BRESP       = bresp_reg;
  assign ARREADY     = arready_reg;
  assign RVALID      = rvalid_reg;
  assign RDATA       = rdata_reg;
  assign RRESP       = rresp_reg;
  assign PHASE_OUT   = pin_out_reg;
  assign PHASE_OE_N  = pin_oe_n_reg;
  assign CARRIER_IRQ = rate_irq;

  // ==================================================================
  // Decoding functions
  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a <= `TPW_OFF_STATUS) && (a[1:0] == 2'h0);
    end
  endfunction

  function [31:0] regmux;
    input [7:0] a;
    begin
      case (a)
        `TPW_OFF_PROTECT:  regmux = {24'h0, prot_reg};
        `TPW_OFF_CTRL_A:   regmux = {24'h0, xfer_arm_reg, ctrl_a_reg[6], st_flag_reg, ctrl_a_reg[4], oe_reg,
                                     ctrl_a_reg[2:0]};
        `TPW_OFF_CTRL_B:   regmux = {24'h0, ctrl_b_reg};
        `TPW_OFF_RATE:     regmux = {{(32-RW){1'b0}}, rate_n};
        `TPW_OFF_CARRIER:  regmux = {{(32-TW){1'b0}}, car_reg};
        `TPW_OFF_TIMER:    regmux = {24'h0, timer_reg};
        `TPW_OFF_BUFFER:   regmux = {16'h0, buf_reg};
        `TPW_OFF_DUTY_U:   regmux = duty_reg[0];
        `TPW_OFF_DUTY_V:   regmux = duty_reg[1];
        `TPW_OFF_DUTY_W:   regmux = duty_reg[2];
        `TPW_OFF_DEADTIME: regmux = {{(32-DW){1'b0}}, dt_reg};
        `TPW_OFF_STATUS:   regmux = {16'h0, 1'b0, mode_reg, car_run_reg, {(8-RW){1'b0}}, rate_u, 4'h0};
        default:           regmux = 32'h0;
      endcase
    end
  endfunction

  function [31:0] wmerge;
    input [31:0] o;
    input [31:0] n;
    input [3:0]  s;
    integer      k;
    begin
      wmerge = o;
      for (k = 0; k < 4; k = k + 1) begin
        if (s[k]) begin
          wmerge[8*k +: 8] = n[8*k +: 8];
        end
      end
    end
  endfunction

  // ==================================================================
  // AXI4-Lite slave
  assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
  assign mw      = wmerge(regmux(wa_reg), wd_reg, ws_reg);

  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `TPW_RESP_OKAY;
      wa_reg      <= 8'h00;
      wd_reg      <= 32'h0;
      ws_reg      <= 4'h0;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= `TPW_RESP_OKAY;
    end else begin
      if (awready_reg && AWVALID) begin
        awready_reg <= 1'b0;
        aw_got_reg  <= 1'b1;
        wa_reg      <= AWADDR;
      end
      if (wready_reg && WVALID) begin
        wready_reg <= 1'b0;
        w_got_reg  <= 1'b1;
        wd_reg     <= WDATA;
        ws_reg     <= WSTRB;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= addr_ok(wa_reg) ? `TPW_RESP_OKAY : `TPW_RESP_SLVERR;
      end
      if (bvalid_reg && BREADY) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
      if (arready_reg && ARVALID) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= regmux(ARADDR);
        rresp_reg   <= addr_ok(ARADDR) ? `TPW_RESP_OKAY : `TPW_RESP_SLVERR;
      end
      if (rvalid_reg && RREADY) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // ==================================================================
  // Carrier timer and mode latch
  assign unit_en   = ctrl_a_reg[`TPW_A_UNIT];
  assign prot_ok   = prot_reg[`TPW_PR_RELEASE];
  assign car_start = timer_reg[`TPW_T_CSTART] && unit_en && !car_run_reg;
  assign uf        = car_run_reg && (car_cnt_reg == {TW{1'b0}});
  assign mode1_act = (mode_reg == `TPW_MODE_TRI1);
  assign reload_ok = !(mode1_act && timer_reg[`TPW_T_CRTS]) || alt_even_reg;
  assign wr_car    = wr_fire && (wa_reg == `TPW_OFF_CARRIER);
  assign xfer_trig  = (xfer_arm_reg && uf) || (wr_car && ctrl_b_reg[`TPW_B_CWSEL]);
  assign xfer_pulse = xfer_trig && ((mode_reg == `TPW_MODE_SAW) || buf_pend_reg);

  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      car_cnt_reg  <= {TW{1'b0}};
      car_lat_reg  <= {TW{1'b0}};
      car_run_reg  <= 1'b0;
      alt_even_reg <= 1'b0;
      mode_reg     <= `TPW_MODE_TRI0;
    end else if (car_start) begin
      car_run_reg  <= 1'b1;
      car_cnt_reg  <= car_reg;
      car_lat_reg  <= car_reg;
      alt_even_reg <= 1'b0;
      mode_reg <= ctrl_a_reg[`TPW_A_SAW] ? `TPW_MODE_SAW :
                  (ctrl_b_reg[`TPW_B_M1] ? `TPW_MODE_TRI1 : `TPW_MODE_TRI0);
    end else if (!timer_reg[`TPW_T_CSTART] || !unit_en) begin
      car_run_reg <= 1'b0;
      if (wr_car) begin
        car_cnt_reg <= mw[TW-1:0];
      end
    end else if (uf) begin
      alt_even_reg <= ~alt_even_reg;
      car_cnt_reg  <= reload_ok ? car_reg : car_lat_reg;
      if (reload_ok) begin
        car_lat_reg <= car_reg;
      end
    end else begin
      car_cnt_reg <= car_cnt_reg - {{(TW-1){1'b0}}, 1'b1};
    end
  end

  // ==================================================================
  // Software registers, output enable and trip flag
  // pair both active trips
  assign trip     = ctrl_a_reg[`TPW_A_STP] && ((raw[0] && raw[1]) || (raw[2] && raw[3]) || (raw[4] && raw[5]));
  assign nmi_fall = nmi_prev_reg && !NMI_N && timer_reg[`TPW_T_NMIEN];

  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      prot_reg     <= `TPW_RST_BYTE;
      ctrl_a_reg   <= `TPW_RST_BYTE;
      ctrl_b_reg   <= `TPW_RST_BYTE;
      timer_reg    <= `TPW_RST_BYTE;
      car_reg      <= `TPW_RST_WORD;
      buf_reg      <= `TPW_RST_WORD;
      dt_reg       <= `TPW_RST_DT;
      oe_reg       <= 1'b0;
      st_flag_reg  <= 1'b0;
      xfer_arm_reg <= 1'b0;
      buf_pend_reg <= 1'b0;
      shift_reg    <= 12'h000;
      nmi_prev_reg <= 1'b1;
      for (i = 0; i < 3; i = i + 1) begin
        duty_reg[i] <= 32'h0;
      end
    end else begin
      nmi_prev_reg <= NMI_N;
      if (wr_fire) begin
        case (wa_reg)
          `TPW_OFF_PROTECT:  prot_reg <= mw[7:0];
          `TPW_OFF_CARRIER:  car_reg <= mw[TW-1:0];
          `TPW_OFF_TIMER:    timer_reg <= mw[7:0];
          `TPW_OFF_BUFFER:   buf_reg <= mw[15:0] & 16'h3F3F;
          `TPW_OFF_DEADTIME: dt_reg <= mw[DW-1:0];
          `TPW_OFF_DUTY_U:   duty_reg[0] <= mw;
          `TPW_OFF_DUTY_V:   duty_reg[1] <= mw;
          `TPW_OFF_DUTY_W:   duty_reg[2] <= mw;
          default:           ;
        endcase
      end
      if (wr_fire && prot_ok && (wa_reg == `TPW_OFF_CTRL_A)) begin
        ctrl_a_reg <= mw[7:0] & `TPW_A_RW_MASK;
        oe_reg     <= mw[`TPW_A_OE];
        if (mw[`TPW_A_XFER]) begin
          xfer_arm_reg <= 1'b1;
        end
      end
      if (wr_fire && prot_ok && (wa_reg == `TPW_OFF_CTRL_B)) begin
        ctrl_b_reg <= mw[7:0];
      end
      if (trip || nmi_fall) begin
        oe_reg <= 1'b0;
      end
      if (trip) begin
        st_flag_reg <= 1'b1;
      end else if (!ctrl_a_reg[`TPW_A_STP]) begin
        st_flag_reg <= 1'b0;
      end
      if (uf) begin
        xfer_arm_reg <= 1'b0;
      end
      if (wr_fire && (wa_reg == `TPW_OFF_BUFFER)) begin
        buf_pend_reg <= 1'b1;
      end else if (xfer_pulse) begin
        buf_pend_reg <= 1'b0;
      end
      if (xfer_pulse) begin
        shift_reg <= {buf_reg[13:8], buf_reg[5:0]};
      end
    end
  end

  // ==================================================================
  // Rate counter and phase channels
  tpw_rate_ctr #(
    .W (RW)
  ) u_rate (
    .clk   (CORE_CLK),
    .nrst  (NRST),
    .en    (unit_en),
    .uf    (uf),
    .mode1 (mode1_act),
    .skip  (ctrl_a_reg[`TPW_A_SKIP]),
    .sync  (ctrl_a_reg[`TPW_A_SYNC]),
    .start (car_start),
    .wr    (wr_fire && (wa_reg == `TPW_OFF_RATE)),
    .wval  (mw[RW-1:0]),
    .nset  (rate_n),
    .ucnt  (rate_u),
    .irq   (rate_irq)
  );

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_phase
      tpw_phase_ch #(
        .TW (TW),
        .DW (DW)
      ) u_ph (
        .clk         (CORE_CLK),
        .nrst        (NRST),
        .en          (unit_en),
        .trig        (uf && timer_reg[`TPW_T_PSTART + g]),
        .alt_mode    (mode1_act),
        .alt_first   (mode1_act && ctrl_b_reg[`TPW_B_M1CTL]),
        .prim        (duty_reg[g][TW-1:0]),
        .sec         (duty_reg[g][16 +: TW]),
        .pair0       (shift_reg[2*g +: 2]),
        .pair1       (shift_reg[6 + 2*g +: 2]),
        .xfer        (xfer_pulse),
        .saw         (mode_reg == `TPW_MODE_SAW),
        .dt_val      (dt_reg),
        .dt_dis      (ctrl_b_reg[`TPW_B_DTDIS]),
        .dt_trig_sel (ctrl_b_reg[`TPW_B_DTTRIG]),
        .out_pair    (raw[2*g +: 2])
      );
    end
  endgenerate

  // ==================================================================
  // Pin drive
  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      pin_out_reg  <= 6'h00;
      pin_oe_n_reg <= 6'h3F;
    end else begin
      pin_out_reg  <= raw & {6{unit_en && oe_reg && !trip}};
      pin_oe_n_reg <= ~{6{unit_en && oe_reg && !trip}};
    end
  end
endmodule // tpw_top

// File: verif/tpw_checker.sv
// Port checker of the inverter PWM control block.
// Assumes one clock domain and binding to tpw_top.
`timescale 1ns/1ns
module tpw_checker (
  input wire        CORE_CLK,
  input wire        NRST,
  input wire        AWVALID,
  input wire        AWREADY,
  input wire        WVALID,
  input wire        WREADY,
  input wire        BVALID,
  input wire        BREADY,
  input wire        ARVALID,
  input wire        ARREADY,
  input wire [7:0]  ARADDR,
  input wire        RVALID,
  input wire        RREADY,
  input wire [31:0] RDATA,
  input wire [1:0]  RRESP,
  input wire [5:0]  PHASE_OUT,
  input wire [5:0]  PHASE_OE_N
);
  // ====
  // Properties
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  AST_OE_UNIFORM: assert property (PHASE_OE_N == 6'h00 || PHASE_OE_N == 6'h3F)
    else $error("pin enables differ");
  AST_FLOAT_LOW: assert property (PHASE_OE_N == 6'h3F |-> PHASE_OUT == 6'h00)
    else $error("floated pin active");
  AST_RST_STATE: assert property (!$past(NRST) |-> PHASE_OE_N == 6'h3F && !BVALID && !RVALID)
    else $error("bad state after reset");
  AST_B_AFTER: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
    else $error("no write answer");
  AST_B_DONE: assert property (BVALID && BREADY |=> !BVALID)
    else $error("write answer held");
  AST_R_AFTER: assert property (ARVALID && ARREADY |-> ##[1:2] RVALID)
    else $error("no read answer");
  AST_R_DONE: assert property (RVALID && RREADY |=> !RVALID)
    else $error("read answer held");
  AST_R_UNMAPPED: assert property (ARVALID && ARREADY && ARADDR > 8'h2C
    |-> ##[1:2] (RVALID && RRESP == 2'h2 && RDATA == 32'h0))
    else $error("unmapped read answered");
endmodule // tpw_checker

bind tpw_top tpw_checker chk (.CORE_CLK(CORE_CLK), .NRST(NRST), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY),
  .RDATA(RDATA), .RRESP(RRESP), .PHASE_OUT(PHASE_OUT), .PHASE_OE_N(PHASE_OE_N));

// File: verif/tpw_gate_model.sv
// Gate driver model on the six phase pins.
// Assumes low enable means driven.
`timescale 1ns/1ns
module tpw_gate_model (
  input  wire        clk,
  input  wire  [5:0] drv,
  input  wire  [5:0] oe_n,
  output logic [5:0] pin
);
  logic [5:0] last_q = 6'h00;
  // Released pins show the inverse of the last driven level.
  always @(posedge clk) last_q <= (drv & ~oe_n) | (last_q & oe_n);
  assign pin = (drv & ~oe_n) | (~last_q & oe_n);
endmodule // tpw_gate_model

// File: verif/testbench.sv
// Self-checking bench of the inverter PWM control block.
// Assumes tpw_top, its checker and the gate model.
`timescale 1ns/1ns
`include "tpw_defines.vh"
module testbench;
  logic        core_clk, nrst, awvalid, wvalid, arvalid, nmi_n;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rd_d;
  logic [1:0]  rd_r;
  wire         awready, wready, bvalid, arready, rvalid, irq;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [5:0]  ph_out, ph_oe_n, pin;
  int          error_cnt, n_compared, seed, gap;
  tpw_top dut (.CORE_CLK(core_clk), .NRST(nrst), .AWVALID(awvalid), .AWREADY(awready),
    .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(4'hF),
    .BVALID(bvalid), .BREADY(1'b1), .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready),
    .ARADDR(araddr), .RVALID(rvalid), .RREADY(1'b1), .RDATA(rdata), .RRESP(rresp),
    .NMI_N(nmi_n), .PHASE_OUT(ph_out), .PHASE_OE_N(ph_oe_n), .CARRIER_IRQ(irq));
  tpw_gate_model gates (.clk(core_clk), .drv(ph_out), .oe_n(ph_oe_n), .pin(pin));
  // ====
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      t++;
    end while (!bvalid && t < 50);
    if (t >= 50) chk(32'h0, 32'h1);
  endtask
  task automatic rd(input logic [7:0] a);
    int t;
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      t++;
    end while (!rvalid && t < 50);
    rd_d = rdata;
    rd_r = rresp;
    if (t >= 50) chk(32'h0, 32'h1);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rd_d & m, e);
    chk({30'h0, rd_r}, 32'h0);
  endtask
  task automatic wirq();
    gap = 0;
    do begin
      @(posedge core_clk);
      gap++;
    end while (irq !== 1'b1 && gap < 400);
  endtask
  task automatic pause();
    repeat (3) @(posedge core_clk);
  endtask
  function automatic int gap_exp(input int md, input int n, input int m);
    return (md == 1) ? n * (m + 1) : m + 1;
  endfunction
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ====
  // Clock, watchdog and tests
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    int n, m, md;
    {nrst, awvalid, wvalid, arvalid, nmi_n} = 5'h01;
    {awaddr, araddr, wdata} = 48'h0;
    {error_cnt, n_compared} = 64'h0;
    seed = 42854;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rc(`TPW_OFF_CTRL_A, 32'hFF, 32'h0);
    rc(`TPW_OFF_DEADTIME, 32'hFF, 32'h1);
    wr(`TPW_OFF_CTRL_A, 32'h04);
    rc(`TPW_OFF_CTRL_A, 32'hFF, 32'h0);
    rd(8'h30);
    chk(rd_d, 32'h0);
    chk({30'h0, rd_r}, 32'h2);
    $display("test reset and protect done");
    wr(`TPW_OFF_PROTECT, 32'h2);
    for (int i = 0; i < 4; i++) begin
      md = (i == 3) ? 1 : i;
      n = (i == 3) ? 15 : 2 + {$random(seed)} % 14;
      m = 3 + {$random(seed)} % 8;
      wr(`TPW_OFF_TIMER, 32'h0);
      wr(`TPW_OFF_RATE, n);
      wr(`TPW_OFF_CTRL_A, (md == 2) ? 32'h45 : ((i == 3) ? 32'h07 : 32'h05));
      wr(`TPW_OFF_CTRL_B, (md == 1) ? 32'h22 : 32'h20);
      wr(`TPW_OFF_CARRIER, m);
      wr(`TPW_OFF_TIMER, 32'h0F);
      rc(`TPW_OFF_STATUS, 32'h6000, md << 13);
      wirq();
      wirq();
      wirq();
      chk(gap, gap_exp(md, n, m));
    end
    wr(`TPW_OFF_TIMER, 32'h0);
    wr(`TPW_OFF_CTRL_A, 32'h00);
    wr(`TPW_OFF_TIMER, 32'h0F);
    wirq();
    chk(gap, 400);
    $display("test rate counter done");
    wr(`TPW_OFF_TIMER, 32'h0);
    wr(`TPW_OFF_CTRL_A, 32'h34);
    rc(`TPW_OFF_CTRL_A, 32'h20, 32'h0);
    wr(`TPW_OFF_BUFFER, 32'h3F3F);
    wr(`TPW_OFF_DUTY_U, 32'h00010001);
    wr(`TPW_OFF_CTRL_A, 32'h9C);
    wr(`TPW_OFF_TIMER, 32'h0F);
    wirq();
    pause();
    chk({26'h0, ph_oe_n}, 32'h3F);
    rc(`TPW_OFF_CTRL_A, 32'h28, 32'h20);
    wr(`TPW_OFF_CTRL_A, 32'h04);
    rc(`TPW_OFF_CTRL_A, 32'h20, 32'h0);
    $display("test shoot-through done");
    wr(`TPW_OFF_TIMER, 32'h10);
    wr(`TPW_OFF_CTRL_A, 32'h0C);
    pause();
    chk({26'h0, ph_oe_n}, 32'h0);
    chk({26'h0, pin}, {26'h0, ph_out});
    nmi_n <= 1'b0;
    pause();
    chk({26'h0, ph_oe_n}, 32'h3F);
    nmi_n <= 1'b1;
    rc(`TPW_OFF_CTRL_A, 32'h08, 32'h0);
    wr(`TPW_OFF_CTRL_A, 32'h0C);
    wr(`TPW_OFF_CTRL_A, 32'h04);
    pause();
    chk({26'h0, ph_oe_n}, 32'h3F);
    $display("test output enable done");
    finish_test();
  end
endmodule // testbench
